// ---- src/gw_fifo_interval.v ----
// gateway fifo: store filtered frames, resend them in order with an interval timer
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "gw_fifo_defines.vh"

// Functional notes
// RULE1: gateway-mode fifo targeted by a matching filter stores and auto-sends the frame.
// RULE2: received frames reach transmit without any processor action.
// RULE3: frames leave strictly in arrival order, oldest first.
// RULE4: arbitration sees only the head frame of the fifo.
// RULE5: in gateway mode host cannot read or write contents; mirror shows sent frames.
// RULE6: when full, keep or drop the newest frame per user setting; code drops the newest while a frame is in flight.
// RULE7: clearing enable discards all frames, then sets empty flag.
// RULE8: while disabled no incoming frame is stored.
// RULE9: on disable with no frame in flight or next, empty is set at once.
// RULE10: with frame in flight or next, empty waits for done, error or lost arbitration.
// RULE11: finishing an abort raises no interrupt.
// RULE12: an in-flight frame that completes may still signal normal transmit complete.
// RULE13: transmit or gateway fifo inserts programmable interval between frames.
// RULE14: timer starts after first successful send, at seventh end-of-frame bit.
// RULE15: on interval elapsed, launch next frame and reset timer.
// RULE16: timer stops on disable or channel reset mode.
// RULE17: bit-time source: tick is nominal bit clock, interval is count ticks.
// RULE18: peripheral source: tick is pclk/2 divided by prescaler, times ten with range bit.
// RULE19: global prescaler is a shared 16-bit field.
// RULE20: per-fifo interval count is an 8-bit field.
// RULE21: transmission starts only when priority selects this fifo.
// RULE22: request to start normally within three bit-time clocks.
module gw_fifo_interval (
   input wire clk_sys_in,
   input wire arst_n_in,
   input wire [3:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [31:0] reg_rdata_out,
   input wire rx_valid_in,
   input wire rx_match_in,
   input wire [31:0] rx_frame_in,
   input wire bit_tick_in,
   input wire chan_reset_in,
   output wire tx_req_out,
   output reg [31:0] tx_frame_out,
   input wire tx_select_in,
   input wire tx_start_in,
   input wire tx_eof7_in,
   input wire tx_error_in,
   input wire tx_arb_lost_in,
   output reg tx_done_out,
   output reg [31:0] mirror_frame_out,
   output reg mirror_valid_out
);

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   reg [31:0] config_ff;
   reg [15:0] prescaler_ff;
   reg [`FRAME_W-1:0] mem [0:`FIFO_DEPTH-1];
   reg [`FIFO_AW:0] wptr_ff;
   reg [`FIFO_AW:0] rptr_ff;
   reg in_flight_ff;
   reg abort_pend_ff;
   reg lost_ff;
   reg started_ff;
   reg timing_ff;
   reg [7:0] ticks_ff;
   reg [19:0] div_ff;
   reg pclk_half_ff;

   wire enable = config_ff[`CFG_ENABLE_BIT];
   wire [1:0] mode = config_ff[`CFG_MODE_MSB:`CFG_MODE_LSB];
   wire keep_new = config_ff[`CFG_KEEP_NEW_BIT];
   wire range_x10 = config_ff[`CFG_RANGE_BIT];
   wire src_bit = config_ff[`CFG_SRC_BIT];
   wire [7:0] interval_count = config_ff[`CFG_COUNT_MSB:`CFG_COUNT_LSB]; //RULE20
   wire gateway = (mode == `MODE_GATEWAY);
   wire sends = gateway || (mode == `MODE_TRANSMIT);

   wire [`FIFO_AW:0] level = wptr_ff - rptr_ff;
   wire empty = (level == {(`FIFO_AW+1){1'b0}});
   // the extra pointer bit is set only when all slots are in use
   wire full = level[`FIFO_AW];

   // word index decode, used by the write paths; the read path decodes with a case
   function reg_hit;
      input [3:0] addr;
      input [3:0] index;
      begin
         reg_hit = (addr == index);
      end
   endfunction

   // a disable write this cycle
   wire cfg_wr = reg_wr_in && reg_hit(reg_addr_in, `REG_FIFO_CONFIG);
   wire disable_now = cfg_wr && enable && !reg_wdata_in[`CFG_ENABLE_BIT];

   // frame finishes on the bus: success, error or lost arbitration
   wire tx_end = in_flight_ff && (tx_eof7_in || tx_error_in || tx_arb_lost_in);
   wire tx_ok = in_flight_ff && tx_eof7_in;

   // ----------------------------------------------------------------
   // interval tick source
   // ----------------------------------------------------------------
   // divisor is prescaler, or ten times it; zero is treated as one
   function [19:0] divisor;
      input [15:0] pre;
      input x10;
      reg [19:0] base;
      begin
         base = (pre == 16'h0000) ? 20'h00001 : {4'h0, pre};
         divisor = x10 ? ((base << 3) + (base << 1)) : base; //RULE18
      end
   endfunction

   wire [19:0] div_max = divisor(prescaler_ff, range_x10); //RULE19
   wire pclk_tick = pclk_half_ff && (div_ff == div_max - 20'h00001);
   wire tick = src_bit ? bit_tick_in : pclk_tick; //RULE17

   // ----------------------------------------------------------------
   // fifo write side
   // ----------------------------------------------------------------
   wire rx_take = rx_valid_in && rx_match_in && enable && gateway; //RULE1 RULE2 RULE8
   // the oldest slot is reused only while in_flight_ff is low, also in the cycle its frame is launched
   wire overwrite = rx_take && full && !keep_new && !in_flight_ff; //RULE6
   wire can_push = rx_take && (!full || overwrite);
   wire rx_lost = rx_take && full && !overwrite;

   // ----------------------------------------------------------------
   // transmit side
   // ----------------------------------------------------------------
   // head frame is offered once the interval is over
   wire ready_gap = !started_ff || (!timing_ff && ticks_ff == 8'h00);
   assign tx_req_out = enable && sends && !empty && !in_flight_ff
                       && !abort_pend_ff && ready_gap; //RULE4 RULE15
   wire launch = tx_req_out && tx_select_in && tx_start_in; //RULE21 RULE22

   // a frame launched in the cycle of the disable counts as in flight
   wire busy_at_disable = (in_flight_ff && !tx_end) || launch;
   wire abort_done = abort_pend_ff && (tx_end || !in_flight_ff);
   wire flush = (disable_now && !busy_at_disable) || abort_done;
   wire hold_queue = disable_now || abort_pend_ff;
   wire push = can_push && !hold_queue;
   wire pop = (tx_ok || overwrite) && !hold_queue;

   // ----------------------------------------------------------------
   // fifo pointers
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wptr_ff <= {(`FIFO_AW+1){1'b0}};
         rptr_ff <= {(`FIFO_AW+1){1'b0}};
      end else begin
         if (push)
            wptr_ff <= wptr_ff + 1'b1;
         if (flush)
            rptr_ff <= wptr_ff; //RULE7 RULE9 RULE10
         else if (pop)
            rptr_ff <= rptr_ff + 1'b1; //RULE3
      end
   end

   // ----------------------------------------------------------------
   // frame storage
   // ----------------------------------------------------------------
   // slots carry no reset: they are only read behind the pointers
   genvar g;
   generate
      for (g = 0; g < `FIFO_DEPTH; g = g + 1) begin : slot
         localparam [`FIFO_AW-1:0] IDX = g;
         always @(posedge clk_sys_in) begin
            if (push && wptr_ff[`FIFO_AW-1:0] == IDX)
               mem[g] <= rx_frame_in; //RULE1
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // frame on the bus and abort
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         in_flight_ff <= 1'b0;
         abort_pend_ff <= 1'b0;
      end else begin
         if (tx_end)
            in_flight_ff <= 1'b0;
         else if (launch)
            in_flight_ff <= 1'b1;
         // a frame on the bus must end before the queue is thrown away
         if (disable_now && busy_at_disable)
            abort_pend_ff <= 1'b1; //RULE10
         else if (abort_done)
            abort_pend_ff <= 1'b0; //RULE11
      end
   end

   // ----------------------------------------------------------------
   // head frame, done pulse and mirror
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_done_out <= 1'b0;
         tx_frame_out <= 32'h0000_0000;
         mirror_frame_out <= 32'h0000_0000;
         mirror_valid_out <= 1'b0;
      end else begin
         tx_frame_out <= mem[rptr_ff[`FIFO_AW-1:0]]; //RULE3
         tx_done_out <= tx_ok; //RULE12
         mirror_valid_out <= tx_ok; //RULE5
         if (tx_ok)
            mirror_frame_out <= tx_frame_out;
      end
   end

   // ----------------------------------------------------------------
   // frame-lost flag
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lost_ff <= 1'b0;
      end else begin
         // set wins over clear
         if (rx_lost)
            lost_ff <= 1'b1;
         else if (reg_wr_in && reg_hit(reg_addr_in, `REG_FIFO_STATUS)
                  && reg_wdata_in[`STS_LOST_BIT])
            lost_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // interval timer
   // ----------------------------------------------------------------
   // restarting the divider with the interval keeps the first tick a full period long
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pclk_half_ff <= 1'b0;
         div_ff <= 20'h00000;
      end else begin
         pclk_half_ff <= ~pclk_half_ff;
         if (!enable || chan_reset_in || disable_now || (tx_ok && sends))
            div_ff <= 20'h00000;
         else if (pclk_half_ff)
            div_ff <= pclk_tick ? 20'h00000 : div_ff + 20'h00001;
      end
   end

   // ----------------------------------------------------------------
   // interval counter
   // ----------------------------------------------------------------
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         started_ff <= 1'b0;
         timing_ff <= 1'b0;
         ticks_ff <= 8'h00;
      end else if (!enable || chan_reset_in || disable_now) begin
         started_ff <= 1'b0; //RULE16
         timing_ff <= 1'b0;
         ticks_ff <= 8'h00;
      end else if (tx_ok && sends) begin
         started_ff <= 1'b1; //RULE14
         timing_ff <= (interval_count != 8'h00); //RULE13
         ticks_ff <= interval_count;
      end else if (timing_ff && tick) begin
         ticks_ff <= ticks_ff - 8'h01;
         if (ticks_ff == 8'h01)
            timing_ff <= 1'b0; //RULE15
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   // status packing; an abort leaves empty low until the queue is flushed
   function [31:0] status_word;
      input lost;
      input [`FIFO_AW:0] lvl;
      input is_full;
      input is_empty;
      begin
         status_word = 32'h0000_0000;
         status_word[`STS_LOST_BIT] = lost;
         status_word[`STS_LEVEL_MSB:`STS_LEVEL_LSB] = lvl;
         status_word[`STS_FULL_BIT] = is_full;
         status_word[`STS_EMPTY_BIT] = is_empty;
      end
   endfunction

   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         config_ff <= `CONFIG_RESET;
         prescaler_ff <= `PRESCALER_RESET;
      end else begin
         if (cfg_wr)
            config_ff <= {16'h0000, reg_wdata_in[15:8], 2'b00, reg_wdata_in[5:0]};
         if (reg_wr_in && reg_hit(reg_addr_in, `REG_GLOBAL_CONFIG))
            prescaler_ff <= reg_wdata_in[15:0]; //RULE19
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (!reg_rd_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         case (reg_addr_in)
            `REG_FIFO_CONFIG: reg_rdata_out <= config_ff;
            `REG_FIFO_STATUS: reg_rdata_out <= status_word(lost_ff, level, full, empty);
            `REG_GLOBAL_CONFIG: reg_rdata_out <= {16'h0000, prescaler_ff};
            // contents hidden in gateway mode
            `REG_MIRROR_DATA: reg_rdata_out <= gateway ? 32'h0000_0000
                                              : mem[rptr_ff[`FIFO_AW-1:0]]; //RULE5
            default: reg_rdata_out <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// ---- src/gw_fifo_defines.vh ----
// constants of the gateway fifo with interval timer
`ifndef GW_FIFO_DEFINES_VH
`define GW_FIFO_DEFINES_VH
// register map (index = byte address / 4)
`define REG_FIFO_CONFIG   4'h0
`define REG_FIFO_STATUS   4'h1
`define REG_GLOBAL_CONFIG 4'h2
`define REG_MIRROR_DATA   4'h3
// fifo_config_reg fields
`define CFG_ENABLE_BIT    0
`define CFG_MODE_LSB      1
`define CFG_MODE_MSB      2
`define CFG_KEEP_NEW_BIT  3
`define CFG_RANGE_BIT     4
`define CFG_SRC_BIT       5
`define CFG_COUNT_LSB     8
`define CFG_COUNT_MSB     15
// fifo_mode_field encodings
`define MODE_RECEIVE      2'h0
`define MODE_TRANSMIT     2'h1
`define MODE_GATEWAY      2'h2
// fifo_status_reg fields
`define STS_EMPTY_BIT     0
`define STS_FULL_BIT      1
`define STS_LEVEL_LSB     8
`define STS_LEVEL_MSB     11
`define STS_LOST_BIT      16
// reset values
`define CONFIG_RESET      32'h0000_0000
`define PRESCALER_RESET   16'h0001
// structure
`define FIFO_DEPTH        8
`define FIFO_AW           3
`define FRAME_W           32
// bit-time clocks allowed from request to start, normally
`define START_DELAY_BITS  3
`endif

// ---- testbench/gw_fifo_checker.sv ----
// port assertions for the gateway fifo
`timescale 1ns/10ps
`include "gw_fifo_defines.vh"
module gw_fifo_checker (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic chan_reset_in,
   input wire logic tx_req_out,
   input wire logic [31:0] tx_frame_out,
   input wire logic tx_select_in,
   input wire logic tx_start_in,
   input wire logic tx_eof7_in,
   input wire logic tx_error_in,
   input wire logic tx_done_out,
   input wire logic [31:0] mirror_frame_out,
   input wire logic mirror_valid_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   wire off_wr = reg_wr_in && reg_addr_in == `REG_FIFO_CONFIG && !reg_wdata_in[`CFG_ENABLE_BIT];
   a_done_after_eof: assert property (tx_done_out |-> $past(tx_eof7_in))
      else $error("done without end of frame");
   a_mirror_with_done: assert property (mirror_valid_out == tx_done_out)
      else $error("mirror pulse apart from done");
   a_mirror_head_frame: assert property (
      mirror_valid_out |-> mirror_frame_out == $past(tx_frame_out))
      else $error("mirror frame is not the head");
   a_start_ends_offer: assert property (
      tx_req_out && tx_select_in && tx_start_in |=> !tx_req_out)
      else $error("offer kept after start");
   a_offer_holds: assert property (
      tx_req_out && !tx_start_in && !reg_wr_in && !chan_reset_in |=> tx_req_out)
      else $error("offer withdrawn without cause");
   a_disable_no_offer: assert property (off_wr |=> !tx_req_out [*2])
      else $error("offer after disable");
   a_error_no_done: assert property (tx_error_in && !tx_eof7_in |=> !tx_done_out)
      else $error("done after bus error");
   a_abort_quiet: assert property (off_wr && !tx_eof7_in |=> !tx_done_out)
      else $error("done on abort");
   cover property (tx_done_out);
   cover property (off_wr);
   cover property (tx_error_in);
endmodule
bind gw_fifo_interval gw_fifo_checker chk (.clk_sys_in, .arst_n_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .chan_reset_in, .tx_req_out, .tx_frame_out, .tx_select_in, .tx_start_in,
   .tx_eof7_in, .tx_error_in, .tx_done_out, .mirror_frame_out, .mirror_valid_out);

// ---- testbench/can_far_node.sv ----
// far-side bus node: grant, frame timing of ten bit ticks, bit tick
`timescale 1ns/10ps
module can_far_node (
   input wire logic clk_sys_in,
   input wire logic tx_req_out,
   input wire logic [1:0] fail_mode_in,
   output wire logic tx_select_in,
   output wire logic tx_start_in,
   output wire logic tx_eof7_in,
   output wire logic tx_error_in,
   output wire logic tx_arb_lost_in,
   output wire logic bit_tick_in
);
   logic [1:0] div_ff = 2'h0;
   logic [3:0] bits_ff = 4'h0;
   logic [3:0] ev_ff = 4'h0;
   logic busy_ff = 1'b0;
   assign bit_tick_in = (div_ff == 2'h3);
   assign tx_select_in = tx_req_out;
   assign {tx_start_in, tx_eof7_in, tx_error_in, tx_arb_lost_in} = ev_ff;
   // mode 3 never starts a frame so frames pile up
   always @(posedge clk_sys_in) begin
      div_ff <= div_ff + 2'h1;
      ev_ff <= 4'h0;
      if (!busy_ff && tx_req_out && bit_tick_in && fail_mode_in != 2'h3) begin
         ev_ff <= 4'h8;
         busy_ff <= 1'b1;
         bits_ff <= 4'h0;
      end else if (busy_ff && bit_tick_in) begin
         bits_ff <= bits_ff + 4'h1;
         if (bits_ff == 4'h9) begin
            busy_ff <= 1'b0;
            ev_ff <= 4'h4 >> fail_mode_in;
         end
      end
   end
endmodule

// ---- testbench/test_can_gateway_fifo_interval.sv ----
// self-checking bench for the gateway fifo
`timescale 1ns/10ps
`include "gw_fifo_defines.vh"
module test_can_gateway_fifo_interval;
   logic clk_sys_in = 0, arst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
   logic rx_valid_in = 0, rx_match_in = 0, chan_reset_in = 0;
   logic [3:0] reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0, rx_frame_in = 32'h0, rd_data;
   logic [1:0] fail_mode = 2'h0;
   wire [31:0] reg_rdata_out, tx_frame_out, mirror_frame_out;
   wire tx_req_out, tx_select_in, tx_start_in, tx_eof7_in, tx_error_in, tx_arb_lost_in;
   wire tx_done_out, mirror_valid_out, bit_tick_in;
   int num_errors = 0, n_compared = 0, t_last, i, k;
   always #50 clk_sys_in = ~clk_sys_in;
   gw_fifo_interval uut (.clk_sys_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .rx_valid_in, .rx_match_in, .rx_frame_in, .bit_tick_in,
      .chan_reset_in, .tx_req_out, .tx_frame_out, .tx_select_in, .tx_start_in, .tx_eof7_in,
      .tx_error_in, .tx_arb_lost_in, .tx_done_out, .mirror_frame_out, .mirror_valid_out);
   can_far_node node (.clk_sys_in, .tx_req_out, .fail_mode_in(fail_mode), .tx_select_in,
      .tx_start_in, .tx_eof7_in, .tx_error_in, .tx_arb_lost_in, .bit_tick_in);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 rd_data = reg_rdata_out;
   endtask
   task automatic rx(input logic [31:0] f, input logic m);
      @(posedge clk_sys_in);
      rx_valid_in <= 1'b1;
      rx_match_in <= m;
      rx_frame_in <= f;
      @(posedge clk_sys_in);
      rx_valid_in <= 1'b0;
   endtask
   task automatic wait_sent(input logic [31:0] exp);
      for (k = 0; k < 1500 && mirror_valid_out !== 1'b1; k++) @(posedge clk_sys_in) #1;
      chk(mirror_frame_out, exp);
      t_last = $time;
      @(posedge clk_sys_in) #1;
   endtask
   // channel reset stops the timer, so the next frame need not wait out the interval
   task automatic t_chan_reset();
      int t1;
      wr(`REG_FIFO_CONFIG, cfg(8'hff, 1'b1, 1'b0, 1'b0));
      rx(32'h7777_0001, 1'b1);
      rx(32'h7777_0002, 1'b1);
      wait_sent(32'h7777_0001);
      t1 = t_last;
      chan_reset_in <= 1'b1;
      @(posedge clk_sys_in);
      chan_reset_in <= 1'b0;
      wait_sent(32'h7777_0002);
      chk(t_last - t1 < 100 * 100, 1'b1);
      wr(`REG_FIFO_CONFIG, 32'h0);
      $display("channel reset test done");
   endtask
   function automatic logic [31:0] cfg(logic [7:0] n, logic src, logic x10, logic keep);
      cfg = {16'h0, n, 2'h0, src, x10, keep, `MODE_GATEWAY, 1'b1};
   endfunction
   task automatic t_order();
      wr(`REG_FIFO_CONFIG, cfg(8'h0, 1'b1, 1'b0, 1'b0));
      rx(32'h1111_0001, 1'b1);
      rx(32'h2222_0002, 1'b0);
      rx(32'h3333_0003, 1'b1);
      rd(`REG_MIRROR_DATA);
      chk(rd_data, 32'h0);
      wait_sent(32'h1111_0001);
      wait_sent(32'h3333_0003);
      wr(`REG_FIFO_CONFIG, 32'h0);
      $display("order test done");
   endtask
   task automatic t_gap(input logic [31:0] c, input int exp);
      int t1;
      wr(`REG_FIFO_CONFIG, c);
      rx(32'ha5a5_0001, 1'b1);
      rx(32'h5a5a_0002, 1'b1);
      wait_sent(32'ha5a5_0001);
      t1 = t_last;
      wait_sent(32'h5a5a_0002);
      chk(t_last - t1 >= (exp + 36) * 100 && t_last - t1 <= (exp + 48) * 100, 1'b1);
      wr(`REG_FIFO_CONFIG, 32'h0);
      $display("interval test done");
   endtask
   task automatic t_full();
      fail_mode <= 2'h3;
      wr(`REG_FIFO_CONFIG, cfg(8'h0, 1'b1, 1'b0, 1'b1));
      for (i = 0; i < 9; i++) rx(32'hf000_0000 + i, 1'b1);
      rd(`REG_FIFO_STATUS);
      chk(rd_data, 32'h0001_0802);
      wr(`REG_FIFO_CONFIG, 32'h0);
      rd(`REG_FIFO_STATUS);
      chk(rd_data & 32'hfff, 32'h1);
      rx(32'hdead_0001, 1'b1);
      rd(`REG_FIFO_STATUS);
      chk(rd_data & 32'hfff, 32'h1);
      $display("full test done");
   endtask
   // each way a frame in flight can end, aborted by disable
   task automatic t_abort(input logic [1:0] m);
      fail_mode <= m;
      wr(`REG_FIFO_CONFIG, cfg(8'h0, 1'b1, 1'b0, 1'b0));
      rx(32'hcafe_0000 + m, 1'b1);
      for (k = 0; k < 20 && tx_start_in !== 1'b1; k++) @(posedge clk_sys_in) #1;
      wr(`REG_FIFO_CONFIG, 32'h0);
      rd(`REG_FIFO_STATUS);
      chk(rd_data[0], 1'b0);
      for (k = 0; k < 60 && {tx_eof7_in, tx_error_in, tx_arb_lost_in} == 0; k++)
         @(posedge clk_sys_in) #1;
      rd(`REG_FIFO_STATUS);
      chk(rd_data & 32'hfff, 32'h1);
      $display("abort test done");
   endtask
   task automatic summarize();
      $display("compared %0d, wrong %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      rd(`REG_FIFO_STATUS);
      chk(rd_data, 32'h1);
      wr(`REG_GLOBAL_CONFIG, 32'hffff_ffff);
      rd(`REG_GLOBAL_CONFIG);
      chk(rd_data, 32'h0000_ffff);
      rd(4'h7);
      chk(rd_data, 32'h0);
      t_order();
      wr(`REG_GLOBAL_CONFIG, 32'h2);
      t_gap(cfg(8'hff, 1'b1, 1'b0, 1'b0), 1020);
      t_gap(cfg(8'h3, 1'b0, 1'b0, 1'b0), 12);
      t_gap(cfg(8'h1, 1'b0, 1'b1, 1'b0), 40);
      t_chan_reset();
      t_full();
      for (i = 0; i < 3; i++) t_abort(i[1:0]);
      summarize();
   end
   initial begin
      #3000000;
      num_errors++;
      summarize();
   end
endmodule
